//--- core/pmsr_pkg.sv
// Constants shared by the power-management status and bus-retract register block
package pmsr_pkg;
  // Register byte offsets on the plain register port
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_ID        = 8'h10;
  localparam logic [7:0]  OFS_RETRACT   = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h20;
  // Revision code, value is arbitrary
  localparam logic [31:0] REV_ID_VALUE  = 32'h0000_0a5a;
  // Retract control fields
  localparam int          RB_DELAY      = 0;
  localparam int          RB_ENABLE     = 1;
  localparam logic [3:0]  RETRACT_SHORT = 4'h8;
  localparam logic [3:0]  RETRACT_LONG  = 4'hc;
  // Status fields
  localparam int          ST_POR        = 0;
  localparam int          ST_PLL_LO     = 1;
  localparam int          ST_EVT_LO     = 4;
  localparam int          ST_FLAG_HI    = 8;
  localparam int          ST_EN_LO      = 9;
  localparam int          ST_EN_HI      = 12;
  localparam int          ST_WARM       = 13;
  localparam logic [8:0]  FLAGS_RST     = 9'h001;
  localparam logic [3:0]  EN_RST        = 4'h0;
  // Timing
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TICK_PERIOD_NS = 4_000_000;
  localparam int          FILT_TICKS     = 4;
  localparam int          WARM_PULSE     = 16;
endpackage : pmsr_pkg

//--- core/pmsr_event_filter.sv
// Slow-tick glitch filter that turns a noisy level into a one-cycle event pulse
`timescale 1ns/100ps
module pmsr_event_filter #(
  parameter int TICKS = 4                // Samples that must agree
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic tick_i,              // Slow sampling tick
  input  wire logic level_i,             // Synchronised, active high
  output logic      event_o              // Pulse on filtered assertion
);
  logic [TICKS-1:0] hist;                // Sample history
  logic             state;               // Filtered level

  generate
    if (TICKS < 2) begin : g_chk
      $error("pmsr_event_filter needs at least two samples");
    end
  endgenerate

  // Sample only on the tick, so short glitches never reach the flags
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hist <= '0;
    end else if (tick_i) begin
      hist <= {hist[TICKS-2:0], level_i};
    end
  end

  // Filtered level moves only when all samples agree
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state   <= 1'b0;
      event_o <= 1'b0;
    end else begin
      event_o <= 1'b0;
      if (tick_i && (&hist) && !state) begin
        state   <= 1'b1;
        event_o <= 1'b1;
      end else if (tick_i && !(|hist)) begin
        state   <= 1'b0;
      end
    end
  end
endmodule : pmsr_event_filter

//--- core/pmsr_regs.sv
// Power-management revision, bus-retract and reset/status registers
// Operation
// [RL1] Revision register reads fixed constant, read-only
// [RL2] Delay bit picks 8 or 12 cycles
// [RL3] Enabled retract when wait held past threshold
// [RL4] Retract frees internal bus for DMA
// [RL5] Event flags sticky until software clears
// [RL6] Bit 0 shows power-on reset seen
// [RL7] Bits 1-3 latch PLL lock loss
// [RL8] Bits 4-8 latch filtered wake events
// [RL9] Bits 9-12 are interrupt enables
// [RL10] Interrupt is level, enable after event works
// [RL11] Write one to bit 0 clears
// [RL12] Write one to bits 1-3 clears
// [RL13] Write one to bits 4-7 clears
// [RL14] Write one to bit 8 clears
// [RL15] Write one to bit 13 pulses warm reset
// [RL16] Software reads status after each reset
// [RL17] Enabled events merge into one interrupt
// [RL18] Noisy inputs retimed to slow tick, filtered
// [RL19] Event beats simultaneous clear
// [RL20] Hold counter restarts each access, counts waits
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module pmsr_regs
  import pmsr_pkg::*;
#(
  parameter int TICK_CYCLES = pmsr_pkg::TICK_PERIOD_NS / pmsr_pkg::CLK_PERIOD_NS
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic [pmsr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                wr_data_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rd_data_o,
  input  wire logic                       ext_access_start_i,
  input  wire logic                       card_a_wait_n_i,
  input  wire logic                       card_b_wait_n_i,
  input  wire logic                       expansion_ready_i,
  output logic                            bus_retract_o,
  input  wire logic [2:0]                 pll_lock_i,
  input  wire logic                       wake_key_n_i,
  input  wire logic                       modem_ring_in_i,
  input  wire logic                       alarm_i,
  input  wire logic                       adapter_ok_in_i,
  input  wire logic                       warm_reset_n_i,
  output logic                            warm_reset_n_o,
  output logic                            pmu_irq_o
);
  import pmsr_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NS = 11;                // Asynchronous pins synchronised

  generate
    if (TICK_CYCLES < 2) begin : g_chk
      $error("pmsr_regs TICK_CYCLES must be at least 2");
    end
  endgenerate

  logic [1:0]    retract_ctrl;           // Delay select and enable
  logic [8:0]    event_flags;            // Sticky flags, bit 0 is power-on
  logic [3:0]    irq_enable;             // Per-source enables
  logic [NS-1:0] sync_a;                 // First synchroniser stage
  logic [NS-1:0] sync_b;                 // Second synchroniser stage
  logic [TW-1:0] tick_cnt;               // Slow tick divider
  logic          tick;                   // One-cycle slow tick
  logic [4:0]    evt_level;              // Event levels, active high
  logic [4:0]    evt_pulse;              // Filtered event pulses
  logic [3:0]    hold_cnt;               // Cycles the wait has been held
  logic          retracted;              // Retract issued for this access
  logic          hold_act;               // Any wait or not-ready active
  logic [3:0]    hold_thr;               // Selected threshold
  logic [4:0]    warm_cnt;               // Warm reset pulse length
  logic          status_wr;              // Write to status register
  logic [8:0]    flag_set;               // Hardware sets this cycle
  logic [8:0]    flag_clr;               // Software clears this cycle

  // Two-flop synchroniser for every pin from outside the clock domain
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync_a <= {NS{1'b1}};
      sync_b <= {NS{1'b1}};
    end else begin
      sync_a <= {expansion_ready_i, card_b_wait_n_i, card_a_wait_n_i, warm_reset_n_i,
                 adapter_ok_in_i, alarm_i, modem_ring_in_i, wake_key_n_i, pll_lock_i};
      sync_b <= sync_a;
    end
  end

  // Slow tick for the event filters
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;                  // see [RL18]
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Active-high levels: on key, ring, alarm, adapter lost, warm reset pin
  assign evt_level = {~sync_b[7], ~sync_b[6], sync_b[5], sync_b[4], ~sync_b[3]};

  // One filter per noisy source
  generate
    for (genvar g = 0; g < 5; g++) begin : g_filt
      pmsr_event_filter #(
        .TICKS (FILT_TICKS)
      ) u_filt (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (tick),
        .level_i (evt_level[g]),         // see [RL18]
        .event_o (evt_pulse[g])
      );
    end
  endgenerate

  // Set and clear terms for the sticky flags
  assign status_wr = wr_i && (addr_i == OFS_STATUS);
  assign flag_set  = {evt_pulse, ~sync_b[2:0], 1'b0};        // see [RL7] see [RL8]
  assign flag_clr  = status_wr ? wr_data_i[ST_FLAG_HI:ST_POR] : '0; // see [RL11] see [RL12]

  // Sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      event_flags <= FLAGS_RST;          // see [RL6]
    end else begin
      event_flags <= (event_flags & ~flag_clr) | flag_set; // see [RL5] see [RL13] see [RL14] see [RL19]
    end
  end

  // Interrupt enables are plain read/write bits
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_enable <= EN_RST;
    end else if (status_wr) begin
      irq_enable <= wr_data_i[ST_EN_HI:ST_EN_LO]; // see [RL9]
    end
  end

  // Level interrupt: re-enabling after the event still raises it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pmu_irq_o <= 1'b0;
    end else begin
      pmu_irq_o <= |(irq_enable & event_flags[7:4]); // see [RL10] see [RL17]
    end
  end

  // Warm reset output held low for a fixed pulse after the trigger write
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      warm_cnt       <= '0;
      warm_reset_n_o <= 1'b1;
    end else if (status_wr && wr_data_i[ST_WARM]) begin
      warm_cnt       <= 5'(WARM_PULSE - 1);
      warm_reset_n_o <= 1'b0;            // see [RL15]
    end else if (warm_cnt != '0) begin
      warm_cnt       <= warm_cnt - 1'b1;
    end else begin
      warm_reset_n_o <= 1'b1;
    end
  end

  // Retract control register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      retract_ctrl <= '0;
    end else if (wr_i && (addr_i == OFS_RETRACT)) begin
      retract_ctrl <= wr_data_i[RB_ENABLE:RB_DELAY];
    end
  end

  // Wait lines are active low; the expansion ready line holds while low
  assign hold_act = !sync_b[8] || !sync_b[9] || !sync_b[10];
  assign hold_thr = retract_ctrl[RB_DELAY] ? RETRACT_LONG : RETRACT_SHORT; // see [RL2]

  // Hold counter: restarts per access, advances only while held, saturates
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hold_cnt <= '0;
    end else if (ext_access_start_i) begin
      hold_cnt <= '0;                    // see [RL20]
    end else if (hold_act && (hold_cnt != hold_thr)) begin
      hold_cnt <= hold_cnt + 1'b1;       // see [RL20]
    end
  end

  // One retract pulse per access once the wait outlasts the threshold
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      retracted     <= 1'b0;
      bus_retract_o <= 1'b0;
    end else if (ext_access_start_i) begin
      retracted     <= 1'b0;
      bus_retract_o <= 1'b0;
    end else if (retract_ctrl[RB_ENABLE] && hold_act && (hold_cnt == hold_thr) && !retracted) begin
      retracted     <= 1'b1;
      bus_retract_o <= 1'b1;             // see [RL3] see [RL4]
    end else begin
      bus_retract_o <= 1'b0;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_ID:      rd_data_o <= REV_ID_VALUE; // see [RL1]
        OFS_RETRACT: rd_data_o <= {30'h0, retract_ctrl};
        // Bit 13 is a write-only trigger and always reads zero
        OFS_STATUS:  rd_data_o <= {18'h0, 1'b0, irq_enable, event_flags};
        default:     rd_data_o <= '0;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  AST_ID_CONST: assert property (rd_i && addr_i == OFS_ID |=> rd_data_o == REV_ID_VALUE) // see [RL1]
    else $error("revision read wrong");
  AST_RETRACT_THR: assert property (bus_retract_o |-> $past(hold_cnt) == $past(hold_thr) // see [RL2]
    && $past(hold_act)) else $error("retract at wrong count");
  AST_RETRACT_OFF: assert property (!retract_ctrl[RB_ENABLE] |=> !bus_retract_o) // see [RL3]
    else $error("retract while disabled");
  AST_STICKY: assert property (!status_wr |=> ($past(event_flags) & ~event_flags) == 9'h000) // see [RL5]
    else $error("flag dropped without clear");
  AST_POR_CLR: assert property (status_wr && wr_data_i[ST_POR] |=> !event_flags[ST_POR]) // see [RL11]
    else $error("power-on flag not cleared");
  AST_PLL_SET: assert property (!sync_b[0] |=> event_flags[ST_PLL_LO]) // see [RL7]
    else $error("display pll unlock not latched");
  AST_SET_WINS: assert property (evt_pulse[0] |=> event_flags[ST_EVT_LO]) // see [RL19]
    else $error("on key event lost");
  AST_ENABLE_WR: assert property (status_wr |=> irq_enable == $past(wr_data_i[ST_EN_HI:ST_EN_LO])) // see [RL9]
    else $error("enable write lost");
  AST_IRQ_LEVEL: assert property (|(irq_enable & event_flags[7:4]) |=> pmu_irq_o) // see [RL10]
    else $error("interrupt not raised");
  AST_IRQ_QUIET: assert property (!(|(irq_enable & event_flags[7:4])) |=> !pmu_irq_o) // see [RL17]
    else $error("spurious interrupt");
  AST_WARM: assert property (status_wr && wr_data_i[ST_WARM] |=> !warm_reset_n_o [*8]) // see [RL15]
    else $error("warm reset pulse short");
  AST_RESTART: assert property (ext_access_start_i |=> hold_cnt == 4'h0) // see [RL20]
    else $error("hold counter not restarted");

  COV_RETRACT: cover property (bus_retract_o);
  COV_IRQ: cover property (!pmu_irq_o ##1 pmu_irq_o);
  COV_WARM: cover property (!warm_reset_n_o);
  COV_CLR_SET: cover property (status_wr && |(wr_data_i[8:4] & flag_set[8:4]));
endmodule : pmsr_regs

//--- sim/pmsr_slow_periph.sv
// Slow external peripheral that holds one wait line for a set number of cycles
`timescale 1ns/100ps
module pmsr_slow_periph (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,              // Begin one external access
  input  wire logic [1:0] line_i,            // 0 card a, 1 card b, 2 expansion
  input  wire logic [4:0] hold_i,            // Cycles the line stays active
  output logic            start_o,           // Access start marker
  output logic            card_a_wait_n_o,
  output logic            card_b_wait_n_o,
  output logic            expansion_ready_o
);
  logic [4:0] left;                          // Remaining held cycles
  logic [1:0] line;                          // Line being held
  // Start pulse and pin hold begin in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      left    <= 5'h00;
      line    <= 2'h0;
      start_o <= 1'b0;
    end else begin
      start_o <= go_i;
      if (go_i) begin
        left <= hold_i;
        line <= line_i;
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
      end
    end
  end
  // Released lines return to their pulled-up idle level
  assign card_a_wait_n_o   = !(left != 5'h00 && line == 2'h0);
  assign card_b_wait_n_o   = !(left != 5'h00 && line == 2'h1);
  assign expansion_ready_o = !(left != 5'h00 && line == 2'h2);
endmodule : pmsr_slow_periph

//--- sim/pmsr_regs_tb.sv
// Self-checking bench for the power-management register block
`timescale 1ns/100ps
module pmsr_regs_tb;
  import pmsr_pkg::*;
  logic        clock_i = 1'b0;            // 100 MHz clock
  logic        rst_n_i = 1'b0;            // Synchronous reset, active low
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [1:0]  line = 2'h0;               // Held wait line
  logic [4:0]  hold = 5'h00;              // Held cycles
  logic [2:0]  pll = 3'h7;                // High is locked
  logic [4:0]  ev = 5'h00;                // Event sources, active high here
  logic [31:0] rdata;
  logic        start, wa_n, wb_n, xrdy, retract, warm_n, irq;
  logic [8:0]  m_flags;                   // Model sticky flags
  logic [3:0]  m_en;                      // Model enables
  int          num_errors = 0, cmp_count = 0, nret = 0;
  always #5 clock_i = ~clock_i;
  // Count retract pulses; one per access at most
  always @(posedge clock_i) if (retract === 1'b1) nret <= nret + 1;
  pmsr_regs #(.TICK_CYCLES(4)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .ext_access_start_i(start), .card_a_wait_n_i(wa_n),
    .card_b_wait_n_i(wb_n), .expansion_ready_i(xrdy), .bus_retract_o(retract), .pll_lock_i(pll),
    .wake_key_n_i(~ev[0]), .modem_ring_in_i(ev[1]), .alarm_i(ev[2]), .adapter_ok_in_i(~ev[3]),
    .warm_reset_n_i(~ev[4]), .warm_reset_n_o(warm_n), .pmu_irq_o(irq));
  pmsr_slow_periph u_periph (.clock_i(clock_i), .rst_n_i(rst_n_i), .go_i(go), .line_i(line), .hold_i(hold),
    .start_o(start), .card_a_wait_n_o(wa_n), .card_b_wait_n_o(wb_n), .expansion_ready_o(xrdy));
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input string what, input logic [31:0] exp);
    @(posedge clock_i);
    rd <= 1'b1; addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_reg
  // Ones in flag bits clear, enable field is replaced
  task automatic wr_status(input logic [31:0] d);
    wr_reg(OFS_STATUS, d);
    m_flags = m_flags & ~d[8:0];
    m_en = d[12:9];
  endtask : wr_status
  task automatic rd_status();
    rd_reg(OFS_STATUS, "status", {19'h0, m_en, m_flags});
  endtask : rd_status
  // New enables show on the interrupt one cycle after the write lands
  task automatic chk_irq();
    cyc(1);
    chk("irq", {31'h0, |(m_flags[7:4] & m_en)}, {31'h0, irq});
  endtask : chk_irq
  task automatic do_reset(input int n);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (n) @(posedge clock_i);
    rst_n_i <= 1'b1;
    m_flags = 9'h001;
    m_en = 4'h0;
    cyc(3);
  endtask : do_reset
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] d;
    int          thr, base;
    void'($urandom(96686));
    do_reset(12);
    rd_status();
    rd_reg(OFS_ID, "id", REV_ID_VALUE);
    wr_reg(OFS_ID, $urandom);
    rd_reg(OFS_ID, "id after write", REV_ID_VALUE);
    rd_reg(8'h44, "unmapped", 32'h0);
    rd_reg(OFS_RETRACT, "retract reset", 32'h0);
    // Short accesses back to back would sum past the threshold without a restart
    for (int k = 0; k < 8; k++) begin
      thr = k[0] ? 12 : 8;
      d = $urandom;
      d[1:0] = k[1:0];
      wr_reg(OFS_RETRACT, d);
      rd_reg(OFS_RETRACT, "retract ctl", {30'h0, k[1:0]});
      base = nret;
      @(posedge clock_i);
      go <= 1'b1; line <= $urandom_range(0, 2);
      hold <= k[2] ? thr + $urandom_range(4, 8) : thr - 3;
      @(posedge clock_i);
      go <= 1'b0;
      cyc(40);
      chk("retract pulses", (k[1] && k[2]) ? 1 : 0, nret - base);
    end
    wr_status(32'h0);
    rd_status();
    wr_status(32'h1);
    rd_status();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      pll[i] <= 1'b0;
      repeat (2) @(posedge clock_i);
      pll[i] <= 1'b1;
      cyc(6);
      m_flags[1 + i] = 1'b1;
      rd_status();
    end
    wr_status(32'h0);
    rd_status();
    wr_status(32'he);
    rd_status();
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      ev[i] <= 1'b1;
      repeat (40) @(posedge clock_i);
      ev[i] <= 1'b0;
      cyc(40);
      m_flags[4 + i] = 1'b1;
      rd_status();
      wr_status($urandom & 32'h1e00);
      chk_irq();
      wr_status(32'h1e00);
      chk_irq();
      wr_status(32'h1e00 | (32'h10 << i));
      chk_irq();
      rd_status();
    end
    wr_status(32'h2000);
    chk("warm out start", 32'h0, {31'h0, warm_n});
    cyc(15);
    chk("warm out end", 32'h0, {31'h0, warm_n});
    cyc(1);
    chk("warm out released", 32'h1, {31'h0, warm_n});
    rd_status();
    do_reset(3);
    rd_status();
    stop_test();
  end
endmodule : pmsr_regs_tb
